// ---- shared/state_readout_pkg.sv ----
package state_readout_pkg;
    localparam logic [15:0] HANDLE_RSVD_LO = 16'h0000;
    localparam logic [15:0] HANDLE_RSVD_HI = 16'hffff;
    localparam logic [7:0] CC_SUCCESS = 8'h00;
    localparam logic [7:0] CC_BAD_HANDLE = 8'h80;
    localparam int MAX_SETS = 8;
    localparam logic [3:0] SET_COUNT_MIN = 4'h1;
    localparam logic [3:0] SET_COUNT_MAX = 4'h8;
    localparam logic [7:0] STATE_UNKNOWN = 8'h00;
    localparam logic [5:0] HDR_BYTES = 6'h02;
    localparam int REC_BYTES = 4;
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_MASK = 8'h08;
    localparam logic [7:0] OFS_INFO = 8'h0c;
    localparam logic [7:0] OFS_INIT = 8'h10;
    localparam int CTRL_HANDLE_LSB = 0;
    localparam int CTRL_COUNT_LSB = 16;
    localparam logic [31:0] CTRL_RESET = 32'h0001_0001;
    localparam int INFO_BUSY_BIT = 8;
    localparam int IRQ_W = 4;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_BADH = 1;
    localparam int IRQ_CHANGE = 2;
    localparam int IRQ_EVENT = 3;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef struct packed {
        logic [15:0] handle;
        logic [7:0] rearmMask;
        logic [7:0] reserved;
    } request_t;

    typedef struct packed {
        logic [7:0] opCondition;
        logic [7:0] currentState;
        logic [7:0] priorState;
        logic [7:0] lastEventState;
    } state_record_t;

    typedef struct packed {
        logic [7:0] opCondition;
        logic [7:0] state;
        logic evt;
    } assessment_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_SEND = 2'b10
    } resp_state_t;
endpackage

// ---- src/irq_status.sv ----
`timescale 1ns/10ps
`default_nettype none
module irq_status #(
    parameter int W = state_readout_pkg::IRQ_W
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [W-1:0] setBits,
    input wire logic clearOnRead,
    input wire logic [W-1:0] mask,
    output logic [W-1:0] status,
    output logic irq
);
    logic [W-1:0] status_r;
    logic irq_r;
    wire logic [W-1:0] status_nxt = (clearOnRead ? '0 : status_r) | setBits;

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            status_r <= '0;
            irq_r <= 1'b0;
        end else begin
            status_r <= status_nxt;
            irq_r <= |(status_nxt & mask);
        end
    end

    assign status = status_r;
    assign irq = irq_r;
endmodule // irq_status
`default_nettype wire

// ---- src/set_tracker.sv ----
`timescale 1ns/10ps
`default_nettype none
module set_tracker #(
    parameter logic [7:0] UNKNOWN = state_readout_pkg::STATE_UNKNOWN
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic reinit,
    input wire logic rearm,
    input wire logic asmValid,
    input wire state_readout_pkg::assessment_t asmIn,
    output state_readout_pkg::state_record_t record,
    output logic changed,
    output logic eventFired
);
    state_readout_pkg::state_record_t rec_r;
    logic known_r;
    logic armed_r;
    logic changed_r;
    logic event_r;

    wire logic newState = asmValid && (asmIn.state != rec_r.currentState);
    wire logic fire = asmValid && asmIn.evt && armed_r;

    always_ff @(posedge core_clk) begin
        if (!resetn || reinit) begin
            rec_r <= '{UNKNOWN, UNKNOWN, UNKNOWN, UNKNOWN};
            known_r <= 1'b0;
            changed_r <= 1'b0;
        end else begin
            changed_r <= asmValid && known_r && newState;
            if (asmValid) begin
                rec_r.opCondition <= asmIn.opCondition;
                rec_r.currentState <= asmIn.state;
                known_r <= 1'b1;
                if (!known_r) begin
                    rec_r.priorState <= asmIn.state;
                end else if (newState) begin
                    rec_r.priorState <= rec_r.currentState;
                end
            end
            if (fire) begin
                rec_r.lastEventState <= asmIn.state;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            armed_r <= 1'b1;
            event_r <= 1'b0;
        end else begin
            event_r <= fire;
            if (rearm) begin
                armed_r <= 1'b1;
            end else if (fire) begin
                armed_r <= 1'b0;
            end
        end
    end

    assign record = rec_r;
    assign changed = changed_r;
    assign eventFired = event_r;
endmodule // set_tracker
`default_nettype wire

// ---- src/state_sensor_readout.sv ----
// Our own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module state_sensor_readout #(
    parameter int SETS = state_readout_pkg::MAX_SETS
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [state_readout_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [state_readout_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic reqValid,
    output logic reqReady,
    input wire state_readout_pkg::request_t reqData,
    output logic rspValid,
    input wire logic rspReady,
    output logic [7:0] rspData,
    output logic rspLast,
    input wire logic [SETS-1:0] asmValid,
    input wire state_readout_pkg::assessment_t [SETS-1:0] asmIn,
    output logic [SETS-1:0] rearmPulse,
    output logic [SETS-1:0] eventPulse,
    output logic irq
);
    // Register file
    logic [31:0] ctrl_r;
    logic [state_readout_pkg::IRQ_W-1:0] mask_r;
    logic [SETS-1:0] reinit_r;
    logic [7:0] lastCode_r;

    // AXI slave state
    logic awHave_r, wHave_r, bValid_r, arReady_r, rValid_r, awReady_r, wReady_r;
    logic [state_readout_pkg::ADDR_W-1:0] awAddr_r;
    logic [31:0] wData_r, rData_r;
    logic [3:0] wStrb_r;
    logic [1:0] bResp_r, rResp_r;

    // Responder state
    state_readout_pkg::resp_state_t state_r;
    state_readout_pkg::state_record_t [SETS-1:0] snap_r;
    logic [5:0] idx_r, total_r;
    logic [7:0] rspData_r;
    logic rspValid_r, rspLast_r, reqReady_r;
    logic [3:0] cfgCountSnap_r;
    logic [SETS-1:0] rearm_r, events_r;

    state_readout_pkg::state_record_t [SETS-1:0] records;
    logic [SETS-1:0] changed, fired;
    logic [state_readout_pkg::IRQ_W-1:0] irqStatus;

    // Write channel decode
    wire logic awTake = s_axi_awvalid && awReady_r;
    wire logic wTake = s_axi_wvalid && wReady_r;
    wire logic awHave_nxt = awHave_r || awTake;
    wire logic wHave_nxt = wHave_r || wTake;
    wire logic [state_readout_pkg::ADDR_W-1:0] wAddr = awTake ? s_axi_awaddr : awAddr_r;
    wire logic [31:0] wDataNow = wTake ? s_axi_wdata : wData_r;
    wire logic [3:0] wStrbNow = wTake ? s_axi_wstrb : wStrb_r;
    wire logic doWrite = awHave_nxt && wHave_nxt && !bValid_r;
    wire logic [31:0] strbMask = {{8{wStrbNow[3]}}, {8{wStrbNow[2]}},
                                  {8{wStrbNow[1]}}, {8{wStrbNow[0]}}};
    wire logic wrCtrl = doWrite && (wAddr == state_readout_pkg::OFS_CTRL);
    wire logic wrMask = doWrite && (wAddr == state_readout_pkg::OFS_MASK);
    wire logic wrInit = doWrite && (wAddr == state_readout_pkg::OFS_INIT);
    wire logic wrStat = doWrite && (wAddr == state_readout_pkg::OFS_STATUS);
    wire logic wrInfo = doWrite && (wAddr == state_readout_pkg::OFS_INFO);
    wire logic wrOk = wrCtrl || wrMask || wrInit || wrStat || wrInfo;
    wire logic bValid_nxt = doWrite || (bValid_r && !s_axi_bready);

    // Read channel decode
    wire logic arTake = s_axi_arvalid && arReady_r;
    wire logic rdStat = arTake && (s_axi_araddr == state_readout_pkg::OFS_STATUS);
    wire logic rValid_nxt = arTake || (rValid_r && !s_axi_rready);
    logic [31:0] rdMux;
    logic rdHit;
    always_comb begin
        rdMux = 32'h0000_0000;
        rdHit = 1'b1;
        case (s_axi_araddr)
            state_readout_pkg::OFS_CTRL: rdMux = ctrl_r;
            state_readout_pkg::OFS_STATUS: rdMux[state_readout_pkg::IRQ_W-1:0] = irqStatus;
            state_readout_pkg::OFS_MASK: rdMux[state_readout_pkg::IRQ_W-1:0] = mask_r;
            state_readout_pkg::OFS_INFO: begin
                rdMux[7:0] = lastCode_r;
                rdMux[state_readout_pkg::INFO_BUSY_BIT] = (state_r != state_readout_pkg::ST_IDLE);
            end
            state_readout_pkg::OFS_INIT: rdMux = 32'h0000_0000;
            default: rdHit = 1'b0;
        endcase
    end

    // Handle and clamped set count
    wire logic [15:0] cfgHandle = ctrl_r[state_readout_pkg::CTRL_HANDLE_LSB +: 16];
    wire logic [3:0] cfgCountRaw = ctrl_r[state_readout_pkg::CTRL_COUNT_LSB +: 4];
    wire logic [3:0] cfgCount =
        (cfgCountRaw < state_readout_pkg::SET_COUNT_MIN) ? state_readout_pkg::SET_COUNT_MIN :
        (cfgCountRaw > state_readout_pkg::SET_COUNT_MAX) ? state_readout_pkg::SET_COUNT_MAX :
        cfgCountRaw;

    // Request decode
    wire logic reqTake = reqValid && reqReady_r;
    wire logic handleOk = (reqData.handle == cfgHandle)
        && (reqData.handle != state_readout_pkg::HANDLE_RSVD_LO)
        && (reqData.handle != state_readout_pkg::HANDLE_RSVD_HI);
    wire logic [7:0] firstCode = handleOk ? state_readout_pkg::CC_SUCCESS
                                          : state_readout_pkg::CC_BAD_HANDLE;
    wire logic [5:0] firstTotal = handleOk
        ? 6'(state_readout_pkg::HDR_BYTES + 6'(cfgCount) * 6'(state_readout_pkg::REC_BYTES))
        : 6'h01;
    wire logic [7:0] countLimit = (8'h01 << cfgCount) - 8'h01;
    wire logic [SETS-1:0] rearmSel = reqData.rearmMask[SETS-1:0]
        & countLimit[SETS-1:0];

    // Response byte selection
    wire logic rspTake = rspValid_r && rspReady;
    wire logic [5:0] idxNext = idx_r + 6'h01;
    wire logic [5:0] recOfs = idxNext - state_readout_pkg::HDR_BYTES;
    wire logic [2:0] recSel = recOfs[4:2];
    wire logic [1:0] fieldSel = recOfs[1:0];
    wire state_readout_pkg::state_record_t recNow = snap_r[recSel];
    wire logic [7:0] recByte = recNow[31 - 8 * fieldSel -: 8];
    wire logic [7:0] countByte = {4'h0, cfgCountSnap_r};
    wire logic [7:0] byteNext = (idxNext == 6'h01) ? countByte : recByte;

    genvar g;
    generate
        for (g = 0; g < SETS; g++) begin : gen_set
            set_tracker #(
                .UNKNOWN(state_readout_pkg::STATE_UNKNOWN)
            ) u_track (
                .core_clk(core_clk),
                .resetn(resetn),
                .reinit(reinit_r[g]),
                .rearm(rearm_r[g]),
                .asmValid(asmValid[g]),
                .asmIn(asmIn[g]),
                .record(records[g]),
                .changed(changed[g]),
                .eventFired(fired[g])
            );
        end
    endgenerate

    wire logic [state_readout_pkg::IRQ_W-1:0] irqSet = {
        |fired,
        |changed,
        reqTake && !handleOk,
        rspTake && rspLast_r
    };

    irq_status #(
        .W(state_readout_pkg::IRQ_W)
    ) u_irq (
        .core_clk(core_clk),
        .resetn(resetn),
        .setBits(irqSet),
        .clearOnRead(rdStat),
        .mask(mask_r),
        .status(irqStatus),
        .irq(irq)
    );

    // AXI write path
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            awHave_r <= 1'b0;
            wHave_r <= 1'b0;
            awReady_r <= 1'b0;
            wReady_r <= 1'b0;
            bValid_r <= 1'b0;
            bResp_r <= state_readout_pkg::RESP_OKAY;
            awAddr_r <= '0;
            wData_r <= 32'h0000_0000;
            wStrb_r <= 4'h0;
        end else begin
            awHave_r <= awHave_nxt && !doWrite;
            wHave_r <= wHave_nxt && !doWrite;
            awReady_r <= !(awHave_nxt && !doWrite) && !bValid_nxt;
            wReady_r <= !(wHave_nxt && !doWrite) && !bValid_nxt;
            bValid_r <= bValid_nxt;
            if (awTake) awAddr_r <= s_axi_awaddr;
            if (wTake) begin
                wData_r <= s_axi_wdata;
                wStrb_r <= s_axi_wstrb;
            end
            if (doWrite) begin
                bResp_r <= wrOk ? state_readout_pkg::RESP_OKAY : state_readout_pkg::RESP_SLVERR;
            end
        end
    end

    // Registers software writes
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            ctrl_r <= state_readout_pkg::CTRL_RESET;
            mask_r <= '0;
            reinit_r <= '0;
        end else begin
            reinit_r <= wrInit ? wDataNow[SETS-1:0] : '0;
            if (wrCtrl) ctrl_r <= (ctrl_r & ~strbMask) | (wDataNow & strbMask);
            if (wrMask) mask_r <= wDataNow[state_readout_pkg::IRQ_W-1:0];
        end
    end

    // AXI read path
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            arReady_r <= 1'b0;
            rValid_r <= 1'b0;
            rData_r <= 32'h0000_0000;
            rResp_r <= state_readout_pkg::RESP_OKAY;
        end else begin
            rValid_r <= rValid_nxt;
            arReady_r <= !rValid_nxt;
            if (arTake) begin
                rData_r <= rdMux;
                rResp_r <= rdHit ? state_readout_pkg::RESP_OKAY : state_readout_pkg::RESP_SLVERR;
            end
        end
    end

    // Request intake and response stream
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            state_r <= state_readout_pkg::ST_IDLE;
            reqReady_r <= 1'b0;
            rspValid_r <= 1'b0;
            rspLast_r <= 1'b0;
            rspData_r <= 8'h00;
            idx_r <= 6'h00;
            total_r <= 6'h00;
            rearm_r <= '0;
            lastCode_r <= 8'h00;
            cfgCountSnap_r <= 4'h0;
        end else begin
            rearm_r <= '0;
            case (state_r)
                state_readout_pkg::ST_IDLE: begin
                    reqReady_r <= 1'b1;
                    if (reqTake) begin
                        reqReady_r <= 1'b0;
                        state_r <= state_readout_pkg::ST_SEND;
                        rspValid_r <= 1'b1;
                        rspData_r <= firstCode;
                        rspLast_r <= !handleOk;
                        idx_r <= 6'h00;
                        total_r <= firstTotal;
                        lastCode_r <= firstCode;
                        cfgCountSnap_r <= cfgCount;
                        if (handleOk) rearm_r <= rearmSel;
                    end
                end
                state_readout_pkg::ST_SEND: begin
                    if (rspTake) begin
                        if (rspLast_r) begin
                            rspValid_r <= 1'b0;
                            rspLast_r <= 1'b0;
                            state_r <= state_readout_pkg::ST_IDLE;
                        end else begin
                            idx_r <= idxNext;
                            rspData_r <= byteNext;
                            rspLast_r <= (idxNext + 6'h01) == total_r;
                        end
                    end
                end
                default: begin
                    state_r <= state_readout_pkg::ST_IDLE;
                    rspValid_r <= 1'b0;
                    reqReady_r <= 1'b0;
                end
            endcase
        end
    end

    // Snapshot at request take and event pulses delayed one cycle
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            snap_r <= '0;
            events_r <= '0;
        end else begin
            events_r <= fired;
            if (reqTake) snap_r <= records;
        end
    end

    assign s_axi_awready = awReady_r;
    assign s_axi_wready = wReady_r;
    assign s_axi_bvalid = bValid_r;
    assign s_axi_bresp = bResp_r;
    assign s_axi_arready = arReady_r;
    assign s_axi_rvalid = rValid_r;
    assign s_axi_rdata = rData_r;
    assign s_axi_rresp = rResp_r;
    assign reqReady = reqReady_r;
    assign rspValid = rspValid_r;
    assign rspData = rspData_r;
    assign rspLast = rspLast_r;
    assign rearmPulse = rearm_r;
    assign eventPulse = events_r;
endmodule // state_sensor_readout
`default_nettype wire

// ---- test/mgmt_requester.sv ----
`timescale 1ns/10ps
`default_nettype none
module mgmt_requester (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic go,
    input wire logic slow,
    input wire logic [15:0] handle,
    input wire logic [7:0] mask,
    output logic reqValid,
    input wire logic reqReady,
    output var state_readout_pkg::request_t reqData,
    input wire logic rspValid,
    output logic rspReady,
    input wire logic [7:0] rspData,
    input wire logic rspLast,
    output logic done,
    output logic [5:0] nBytes,
    output logic [7:0] rxBytes [0:33]
);
    logic tick_r;
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            reqValid <= 1'b0;
            reqData <= '0;
            rspReady <= 1'b0;
            done <= 1'b0;
            nBytes <= 6'h00;
            tick_r <= 1'b0;
        end else begin
            tick_r <= ~tick_r;
            rspReady <= !slow || tick_r;
            if (go) begin
                reqValid <= 1'b1;
                reqData <= {handle, mask, 8'h00};
                done <= 1'b0;
                nBytes <= 6'h00;
            end else if (reqValid && reqReady) begin
                reqValid <= 1'b0;
                reqData <= ~reqData;
            end
            if (rspValid && rspReady && nBytes < 6'h22) begin
                rxBytes[nBytes] <= rspData;
                nBytes <= nBytes + 6'h01;
                done <= rspLast;
            end
        end
    end
endmodule // mgmt_requester
`default_nettype wire

// ---- test/state_readout_checker.sv ----
`timescale 1ns/10ps
`default_nettype none
module state_readout_checker #(
    parameter int SETS = 8
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic reqValid,
    input wire logic reqReady,
    input wire state_readout_pkg::request_t reqData,
    input wire logic rspValid,
    input wire logic rspReady,
    input wire logic [7:0] rspData,
    input wire logic rspLast,
    input wire logic [SETS-1:0] asmValid,
    input wire state_readout_pkg::assessment_t [SETS-1:0] asmIn,
    input wire logic [SETS-1:0] rearmPulse,
    input wire logic [SETS-1:0] eventPulse
);
    logic [SETS-1:0] evVec;
    logic [5:0] byteIdx_r;
    wire logic take = reqValid && reqReady;
    wire logic badTake = take && (reqData.handle == state_readout_pkg::HANDLE_RSVD_LO
        || reqData.handle == state_readout_pkg::HANDLE_RSVD_HI);
    always_comb begin
        for (int i = 0; i < SETS; i++) begin
            evVec[i] = asmIn[i].evt;
        end
    end
    always_ff @(posedge core_clk) begin
        if (!resetn || take) begin
            byteIdx_r <= 6'h00;
        end else if (rspValid && rspReady) begin
            byteIdx_r <= byteIdx_r + 6'h01;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    sequence bad_code_s;
        rspValid && rspData == 8'h80 && rspLast;
    endsequence
    sequence drain_s;
        !rspValid ##1 reqReady;
    endsequence
    bad_handle_resp_a: assert property (badTake |=> bad_code_s)
        else $error("reserved handle taken");
    bad_no_rearm_a: assert property (badTake |=> rearmPulse == '0)
        else $error("re-arm on reserved handle");
    rearm_after_take_a: assert property (rearmPulse != '0 |-> $past(take))
        else $error("re-arm without request");
    first_code_a: assert property (take |=> rspValid && byteIdx_r == 6'h00
        && (rspData == 8'h00 || rspData == 8'h80))
        else $error("bad completion byte");
    rsp_hold_a: assert property (rspValid && !rspReady |=> rspValid
        && $stable(rspData) && $stable(rspLast))
        else $error("response byte not held");
    count_range_a: assert property (rspValid && byteIdx_r == 6'h01
        |-> rspData >= 8'h01 && rspData <= 8'h08)
        else $error("set count out of range");
    last_align_a: assert property (rspValid && rspLast |->
        (byteIdx_r == 6'h00 && rspData == 8'h80) || (byteIdx_r[1:0] == 2'b01
        && byteIdx_r >= 6'h05 && byteIdx_r <= 6'h21))
        else $error("length not whole records");
    event_pulse_a: assert property (eventPulse != '0
        |-> (eventPulse & ~$past(asmValid & evVec, 2)) == '0)
        else $error("event pulse without event");
    ready_return_a: assert property (rspValid && rspReady && rspLast |=> drain_s)
        else $error("no idle after last byte");
endmodule // state_readout_checker
bind state_sensor_readout state_readout_checker #(.SETS(SETS)) chk (.*);
`default_nettype wire

// ---- test/tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb;
    localparam int SETS = 8;
    logic core_clk, resetn, go, slow, done, irq;
    logic [7:0] s_axi_awaddr, s_axi_araddr, rspData, mask;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic reqValid, reqReady, rspValid, rspReady, rspLast;
    state_readout_pkg::request_t reqData;
    logic [15:0] handle;
    logic [SETS-1:0] asmValid, rearmPulse, eventPulse, rearmSeen, evSeen, evExp;
    state_readout_pkg::assessment_t [SETS-1:0] asmIn;
    logic [5:0] nBytes;
    logic [7:0] rxBytes [0:33];
    bit [7:0] mOp [SETS], mCur [SETS], mPri [SETS], mEv [SETS];
    bit known [SETS], armed [SETS] = '{default: 1'b1};
    logic [15:0] badH [3] = '{16'h0000, 16'hffff, 16'h4321};
    int mismatches, samples_checked;
    state_sensor_readout #(.SETS(SETS)) dut (.core_clk, .resetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .reqValid, .reqReady, .reqData, .rspValid,
        .rspReady, .rspData, .rspLast, .asmValid, .asmIn, .rearmPulse, .eventPulse, .irq);
    mgmt_requester host (.core_clk, .resetn, .go, .slow, .handle, .mask, .reqValid, .reqReady,
        .reqData, .rspValid, .rspReady, .rspData, .rspLast, .done, .nBytes, .rxBytes);
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        rearmSeen <= (go || !resetn) ? '0 : rearmSeen | rearmPulse;
        evSeen <= resetn ? evSeen | eventPulse : '0;
    end
    task automatic report_and_stop();
        $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            mismatches++;
        end
    endtask
    task automatic stall();
        mismatches++;
        report_and_stop();
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        do begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            n++;
        end while (!s_axi_bvalid && n < 50);
        if (n == 50) stall();
        check(s_axi_bresp, er);
        s_axi_bready <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, e, input logic [1:0] er);
        int n = 0;
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        do begin
            @(posedge core_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            n++;
        end while (!s_axi_rvalid && n < 50);
        if (n == 50) stall();
        check(s_axi_rdata & m, e);
        check(s_axi_rresp, er);
        s_axi_rready <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic wait_irq(input logic v);
        int n = 0;
        while (irq !== v && n < 20) begin
            @(posedge core_clk);
            n++;
        end
        if (n == 20) stall();
        check(irq, v);
    endtask
    task automatic assess(input int s, input logic [7:0] op, st, input logic ev);
        asmValid[s] <= 1'b1;
        asmIn[s] <= {op, st, ev};
        mOp[s] = op;
        if (!known[s]) mPri[s] = st;
        else if (st != mCur[s]) mPri[s] = mCur[s];
        mCur[s] = st;
        known[s] = 1'b1;
        if (ev && armed[s]) begin
            mEv[s] = st;
            armed[s] = 1'b0;
            evExp[s] = 1'b1;
        end
        @(posedge core_clk);
        asmValid[s] <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic request(input logic [15:0] h, input logic [7:0] m, input int c, input bit ok);
        int n = 0;
        handle <= h;
        mask <= m;
        go <= 1'b1;
        for (int i = 0; i < c; i++) if (ok && m[i]) armed[i] = 1'b1;
        @(posedge core_clk);
        go <= 1'b0;
        do begin
            @(posedge core_clk);
            n++;
        end while (!done && n < 400);
        if (n == 400) stall();
        check(evSeen, evExp);
        if (!ok) begin
            check(nBytes, 1);
            check(rxBytes[0], 8'h80);
            check(rearmSeen, 0);
        end else begin
            check(nBytes, 2 + 4 * c);
            check(rxBytes[0], 8'h00);
            check(rxBytes[1], c);
            for (int i = 0; i < c; i++) begin
                check(rxBytes[2 + 4 * i], mOp[i]);
                check(rxBytes[3 + 4 * i], mCur[i]);
                check(rxBytes[4 + 4 * i], mPri[i]);
                check(rxBytes[5 + 4 * i], mEv[i]);
            end
            check(rearmSeen, m & ((1 << c) - 1));
        end
    endtask
    initial begin
        {resetn, go, slow, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, handle, mask, s_axi_awaddr, s_axi_araddr} = '0;
        {s_axi_wdata, asmValid, asmIn, evExp} = '0;
        s_axi_wstrb = 4'hf;
        repeat (16) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (2) @(posedge core_clk);
        rd(state_readout_pkg::OFS_CTRL, 32'hffffffff, 32'h0001_0001, 2'b00);
        rd(state_readout_pkg::OFS_STATUS, 32'hffffffff, 32'h0, 2'b00);
        rd(state_readout_pkg::OFS_MASK, 32'hffffffff, 32'h0, 2'b00);
        rd(8'h14, 32'hffffffff, 32'h0, 2'b10);
        wr(8'h14, 32'h1, 2'b10);
        wr(state_readout_pkg::OFS_MASK, 32'h8, 2'b00);
        wr(state_readout_pkg::OFS_CTRL, 32'h0003_1234, 2'b00);
        rd(state_readout_pkg::OFS_CTRL, 32'hffffffff, 32'h0003_1234, 2'b00);
        assess(0, 8'h01, 8'h05, 1'b1);
        wait_irq(1'b1);
        rd(state_readout_pkg::OFS_STATUS, 32'hffffffff, 32'h8, 2'b00);
        wait_irq(1'b0);
        assess(0, 8'h01, 8'h07, 1'b0);
        assess(0, 8'h01, 8'h07, 1'b1);
        assess(1, 8'h02, 8'h09, 1'b0);
        request(16'h1234, 8'hff, 3, 1'b1);
        assess(0, 8'h03, 8'h04, 1'b1);
        assess(1, 8'h02, 8'h09, 1'b1);
        request(16'h1234, 8'h02, 3, 1'b1);
        assess(0, 8'h03, 8'h06, 1'b1);
        assess(1, 8'h02, 8'h0a, 1'b1);
        rd(state_readout_pkg::OFS_STATUS, 32'hf, 32'hd, 2'b00);
        wr(state_readout_pkg::OFS_MASK, 32'h0, 2'b00);
        for (int i = 0; i < 3; i++) request(badH[i], 8'hff, 3, 1'b0);
        check(irq, 1'b0);
        rd(state_readout_pkg::OFS_STATUS, 32'h2, 32'h2, 2'b00);
        rd(state_readout_pkg::OFS_INFO, 32'h1ff, 32'h80, 2'b00);
        wr(state_readout_pkg::OFS_CTRL, 32'h0008_00ff, 2'b00);
        wr(state_readout_pkg::OFS_INIT, 32'h1, 2'b00);
        {mEv[0], known[0]} = '0;
        assess(0, 8'h03, 8'h0c, 1'b0);
        slow <= 1'b1;
        assess(5, 8'h03, 8'h11, 1'b0);
        request(16'h00ff, 8'h80, 8, 1'b1);
        report_and_stop();
    end
endmodule // tb
`default_nettype wire
